// *** mtrm_map.vh ***
/*
  Constants for the memory type range map: register indices, field
  positions, reset values and memory type encodings.
  Assumes inclusion by bare name from the range map design file.
*/
`ifndef MTRM_MAP_VH
`define MTRM_MAP_VH

// Register indices on the model register port
`define MTRM_IDX_CAP      8'h00
`define MTRM_IDX_DEF      8'h01
`define MTRM_IDX_FIX64K   8'h02
`define MTRM_IDX_FIX16K_A 8'h03
`define MTRM_IDX_FIX16K_B 8'h04
`define MTRM_IDX_FIX4K_0  8'h05
`define MTRM_IDX_FIX4K_7  8'h0C
`define MTRM_FIX_COUNT    11

// Capability fields
`define MTRM_CAP_LOWMEM_BIT 8
`define MTRM_CAP_WC_BIT     10
`define MTRM_CAP_SMM_RANGE_SUPPORT_BIT   11

// Default type control fields
`define MTRM_DEF_LOWMEM_BIT 10
`define MTRM_DEF_GLOBAL_BIT 11
`define MTRM_DEF_RSVD_MASK  64'hFFFFFFFFFFFFF300
`define MTRM_DEF_RESET      64'h0000000000000000
`define MTRM_FIX_RESET      64'h0000000000000000

// Memory type encodings
`define MTRM_TYPE_UC 8'h00
`define MTRM_TYPE_WC 8'h01
`define MTRM_TYPE_WT 8'h04
`define MTRM_TYPE_WP 8'h05
`define MTRM_TYPE_WB 8'h06

// Identification feature flag position
`define MTRM_FEAT_BIT 12

// Top of the low-memory region
`define MTRM_LOWMEM_TOP 20'hFFFFF

`endif

// *** mtrm_range_map.v ***
/*
  Memory type range map: capability, default type control and the
  eleven low-memory type registers, plus the type lookup path.
  Assumes the core issues model register reads and writes as one-cycle
  strobes on mclk, and that variable range matching is done outside
  and arrives as a hit flag and type on the same clock.
*/
// Function
// RULE1 - Up to 96 typed ranges in total
// RULE2 - Reset disables all ranges, memory uncacheable
// RULE3 - Type codes 00,01,04,05,06 in bytes
// RULE4 - Reserved type code write faults
// RULE5 - Feature flag bit 12 reports support
// RULE6 - Capability read-only; write faults
// RULE7 - Capability bits 7:0 give variable count
// RULE8 - Capability bit 8 shows low-memory registers
// RULE9 - Capability bit 10 shows write-combining
// RULE10 - Capability bit 11 shows SMM range pair
// RULE11 - Default field types unmapped addresses
// RULE12 - Default type only 0,1,4,5,6 else fault
// RULE13 - Default bit 10 enables low-memory ranges
// RULE14 - Low-memory type beats variable type
// RULE15 - Variable ranges apply when low-memory off
// RULE16 - Global bit clear makes all uncacheable
// RULE17 - Low-memory enable needs global enable
// RULE18 - Nonzero reserved default bits fault
// RULE19 - Eleven 64-bit registers, eight type bytes
// RULE20 - First register: eight 64K sub-ranges
// RULE21 - Two registers: sixteen 16K sub-ranges
// RULE22 - Eight registers: sixty-four 4K sub-ranges
// RULE23 - Lowest sub-range in bits 7:0
// RULE24 - Lookup: low-memory, variable, then default
`include "mtrm_map.vh"
`timescale 1ns/1ps
`default_nettype none

module mtrm_range_map #(
  parameter       ADDR_W      = 36, // Physical address width
  parameter [7:0] VAR_COUNT   = 8'h08, // Variable ranges implemented
  parameter       LOWMEM_IMPL = 1,  // Low-memory registers present
  parameter       WC_IMPL     = 1,  // Write-combining supported
  parameter       SMM_RANGE_SUPPORT_IMPL   = 0   // SMM range pair supported
) (
  input  wire              mclk,
  input  wire              srst,
  input  wire [7:0]        reg_index,
  input  wire              reg_rd,
  input  wire              reg_wr,
  input  wire [63:0]       reg_wdata,
  output reg  [63:0]       reg_rdata_q,
  output reg               reg_rvalid_q,
  output reg               protection_fault_q,
  input  wire              lookup_req,
  input  wire [ADDR_W-1:0] lookup_addr,
  input  wire              var_hit,
  input  wire [7:0]        var_type,
  output reg  [7:0]        mem_type_q,
  output reg               mem_type_valid_q,
  output reg  [31:0]       feature_flags_q
);

  // Default type control and low-memory type registers
  reg  [63:0] def_q;
  reg  [63:0] fix_q [0:`MTRM_FIX_COUNT-1];
  integer     i;

  // Decoded accesses
  wire        hit_cap;
  wire        hit_def;
  wire        hit_fix;
  wire [7:0]  fix_off;  // Full-width offset from the first low-memory index
  wire [3:0]  fix_sel;  // Array slot; offsets above 10 never reach it
  wire [63:0] cap_word;
  wire        global_en;
  wire        lowmem_en;
  wire        in_lowmem;
  wire [3:0]  lk_reg;
  wire [2:0]  lk_byte;
  wire [7:0]  lk_type;

  // Legal memory type code
  function type_ok;
    input [7:0] t;
    begin
      case (t)
        `MTRM_TYPE_UC: type_ok = 1'b1; // RULE3
        `MTRM_TYPE_WC: type_ok = 1'b1;
        `MTRM_TYPE_WT: type_ok = 1'b1;
        `MTRM_TYPE_WP: type_ok = 1'b1;
        `MTRM_TYPE_WB: type_ok = 1'b1;
        default:       type_ok = 1'b0; // RULE4
      endcase
    end
  endfunction

  // All eight type bytes of a word legal
  function bytes_ok;
    input [63:0] w;
    integer k;
    begin
      bytes_ok = 1'b1;
      for (k = 0; k < 8; k = k + 1)
      begin
        if (!type_ok(w[k*8 +: 8]))
          bytes_ok = 1'b0; // RULE4
      end
    end
  endfunction

  // Index decode
  assign hit_cap = (reg_index == `MTRM_IDX_CAP);
  assign hit_def = (reg_index == `MTRM_IDX_DEF);
  assign hit_fix = (LOWMEM_IMPL != 0)
                 && (reg_index >= `MTRM_IDX_FIX64K)
                 && (reg_index <= `MTRM_IDX_FIX4K_7);
  // Subtract at full index width, then keep the slot bits on purpose
  assign fix_off = reg_index - `MTRM_IDX_FIX64K;
  assign fix_sel = fix_off[3:0];

  // Capability word, constant from parameters
  assign cap_word = {52'h0,
                     (SMM_RANGE_SUPPORT_IMPL != 0),   // RULE10
                     (WC_IMPL != 0),     // RULE9
                     1'b0,
                     (LOWMEM_IMPL != 0), // RULE8
                     VAR_COUNT};         // RULE7

  // Enables: low-memory counts only under global enable
  assign global_en = def_q[`MTRM_DEF_GLOBAL_BIT]; // RULE16
  assign lowmem_en = global_en
                   && def_q[`MTRM_DEF_LOWMEM_BIT]
                   && (LOWMEM_IMPL != 0); // RULE13 RULE17

  // Low-memory sub-range select by address
  assign in_lowmem = (lookup_addr[ADDR_W-1:20] == 0);
  // 64K blocks below 80000H, 16K up to BFFFFH, 4K above
  assign lk_reg  = !lookup_addr[19] ? 4'h0 : // RULE20
                   !lookup_addr[18] ?
                     {3'b000, lookup_addr[17]} + 4'h1 : // RULE21
                     {1'b0, lookup_addr[17:15]} + 4'h3; // RULE22
  assign lk_byte = !lookup_addr[19] ? lookup_addr[18:16] :
                   !lookup_addr[18] ? lookup_addr[16:14] :
                                      lookup_addr[14:12];
  // Lowest address in lowest byte
  assign lk_type = fix_q[lk_reg][lk_byte*8 +: 8]; // RULE23

  // Register write path and fault detection
  always @(posedge mclk)
  begin
    if (srst)
    begin
      def_q <= `MTRM_DEF_RESET; // RULE2
      for (i = 0; i < `MTRM_FIX_COUNT; i = i + 1)
        fix_q[i] <= `MTRM_FIX_RESET;
      protection_fault_q <= 1'b0;
    end
    else
    begin
      protection_fault_q <= 1'b0;
      if (reg_wr)
      begin
        if (hit_cap)
          protection_fault_q <= 1'b1; // RULE6
        else if (hit_def)
        begin
          // Reserved bits or bad type: refuse and fault
          if ((reg_wdata & `MTRM_DEF_RSVD_MASK) != 64'h0)
            protection_fault_q <= 1'b1; // RULE18
          else if (!type_ok(reg_wdata[7:0]))
            protection_fault_q <= 1'b1; // RULE12
          else if (!WC_IMPL &&
                   reg_wdata[7:0] == `MTRM_TYPE_WC)
            protection_fault_q <= 1'b1;
          else
            def_q <= reg_wdata; // RULE11
        end
        else if (hit_fix)
        begin
          if (!bytes_ok(reg_wdata))
            protection_fault_q <= 1'b1; // RULE4
          else
            fix_q[fix_sel] <= reg_wdata; // RULE19
        end
        else
          protection_fault_q <= 1'b1; // Unmapped index
      end
      else if (reg_rd && !hit_cap && !hit_def && !hit_fix)
        protection_fault_q <= 1'b1; // Unmapped read
    end
  end

  // Read path, one cycle after the strobe
  always @(posedge mclk)
  begin
    if (srst)
    begin
      reg_rdata_q  <= 64'h0;
      reg_rvalid_q <= 1'b0;
    end
    else
    begin
      reg_rvalid_q <= reg_rd && (hit_cap || hit_def || hit_fix);
      if (reg_rd && hit_cap)
        reg_rdata_q <= cap_word; // RULE6
      else if (reg_rd && hit_def)
        reg_rdata_q <= def_q;
      else if (reg_rd && hit_fix)
        reg_rdata_q <= fix_q[fix_sel];
      else if (reg_rd)
        reg_rdata_q <= 64'h0;
    end
  end

  // Type lookup; 88 low-memory plus the variable ranges
  always @(posedge mclk)
  begin
    if (srst)
    begin
      mem_type_q       <= `MTRM_TYPE_UC;
      mem_type_valid_q <= 1'b0;
    end
    else
    begin
      mem_type_valid_q <= lookup_req;
      if (lookup_req)
      begin
        if (!global_en)
          mem_type_q <= `MTRM_TYPE_UC; // RULE16
        else if (lowmem_en && in_lowmem)
          mem_type_q <= lk_type; // RULE14 RULE24
        else if (var_hit)
          mem_type_q <= var_type; // RULE15 RULE1
        else
          mem_type_q <= def_q[7:0]; // RULE11
      end
    end
  end

  // Identification flag; constant, held in a flop
  always @(posedge mclk)
  begin
    if (srst)
      feature_flags_q <= 32'h0;
    else
      feature_flags_q <= 32'h1 << `MTRM_FEAT_BIT; // RULE5
  end

endmodule

`default_nettype wire

// *** mtrm_range_map_assertions.sv ***
/* Port checks for the range map.
   Assumes one clock and the bind at the foot of this file. */
`timescale 1ns/1ps
`default_nettype none
module mtrm_chk (
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic [7:0]  reg_index,
  input wire logic        reg_rd,
  input wire logic        reg_wr,
  input wire logic [63:0] reg_wdata,
  input wire logic [63:0] reg_rdata_q,
  input wire logic        reg_rvalid_q,
  input wire logic        protection_fault_q,
  input wire logic        lookup_req,
  input wire logic        mem_type_valid_q,
  input wire logic [31:0] feature_flags_q
);
  // All checks share one clock and its reset
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  // Index inside the mapped set
  wire mapped = reg_index <= 8'h0C;
  // Default type control write
  wire def_wr = reg_wr && reg_index == 8'h01;

  AST_RD_ANSWER: assert property (reg_rd && !reg_wr && mapped
    |=> reg_rvalid_q && !protection_fault_q) else $error("read unanswered");
  AST_UNMAPPED: assert property ((reg_rd || reg_wr) && !mapped
    |=> protection_fault_q && !reg_rvalid_q) else $error("unmapped taken");
  AST_CAP_RO: assert property (reg_wr && reg_index == 8'h00
    |=> protection_fault_q) else $error("capability written");
  AST_CAP_VAL: assert property (reg_rd && !reg_wr && reg_index == 8'h00
    |=> reg_rdata_q == 64'h508) else $error("capability wrong");
  AST_DEF_RSVD: assert property (def_wr
    && (reg_wdata & 64'hFFFFFFFFFFFFF300) != 64'h0 |=> protection_fault_q)
    else $error("reserved bits taken");
  AST_DEF_TYPE: assert property (def_wr
    && !(reg_wdata[7:0] inside {8'h00, 8'h01, 8'h04, 8'h05, 8'h06})
    |=> protection_fault_q) else $error("bad default type taken");
  AST_LK_ANS: assert property (lookup_req |=> mem_type_valid_q)
    else $error("lookup unanswered");
  AST_FEAT: assert property (!$past(srst)
    |-> feature_flags_q == 32'h1000) else $error("feature flag wrong");
endmodule
bind mtrm_range_map mtrm_chk u_chk (.mclk, .srst, .reg_index, .reg_rd,
  .reg_wr, .reg_wdata, .reg_rdata_q, .reg_rvalid_q, .protection_fault_q,
  .lookup_req, .mem_type_valid_q, .feature_flags_q);
`default_nettype wire

// *** mtrm_tb.sv ***
/* Self-checking bench for the range map.
   Assumes the design's default parameters. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        mclk, srst, reg_rd, reg_wr, lookup_req, var_hit;
  logic        reg_rvalid_q, protection_fault_q, mem_type_valid_q;
  logic [7:0]  reg_index, var_type, mem_type_q;
  logic [63:0] reg_wdata, reg_rdata_q, defq, d;
  logic [35:0] lookup_addr;
  logic [31:0] feature_flags_q;
  logic [64:0] eq[$];       // Pending register answers
  logic [7:0]  tq[$];       // Pending lookup types
  logic [63:0] fx[11];      // Shadow of the low-memory registers
  logic [7:0]  lg[5] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06};
  logic [35:0] ba[6] = '{36'h7FFFF, 36'h80000, 36'hBFFFF, 36'hC0000,
                         36'hFFFFF, 36'h100000};
  int          fails, n_tests, i, k;

  mtrm_range_map DUT (.mclk, .srst, .reg_index, .reg_rd, .reg_wr, .reg_wdata,
    .reg_rdata_q, .reg_rvalid_q, .protection_fault_q, .lookup_req,
    .lookup_addr, .var_hit, .var_type, .mem_type_q, .mem_type_valid_q,
    .feature_flags_q);

  initial
  begin
    mclk = 0;
    forever #10 mclk = ~mclk;
  end

  task print_verdict;
    if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task chk_reg(input logic [64:0] e, input logic [64:0] g);
    n_tests++;
    if (e !== g)
    begin
      fails++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task chk_type(input logic [7:0] e, input logic [7:0] g);
    chk_reg({57'h0, e}, {57'h0, g});
  endtask

  // One request cycle; variable match inputs always random
  task op(input logic r, w, input logic [7:0] x, input logic [63:0] v,
          input logic l, input logic [35:0] a);
    @(posedge mclk);
    #1;
    {reg_rd, reg_wr, reg_index, reg_wdata, lookup_req} = {r, w, x, v, l};
    {lookup_addr, var_hit, var_type} = {a, 1'($urandom), lg[$urandom % 5]};
  endtask

  task wr(input logic [7:0] x, input logic [63:0] v, input logic f);
    op(0, 1, x, v, 0, 0);
    if (f) eq.push_back({1'b1, 64'h0});
    else if (x == 8'h01) defq = v;
    else fx[x - 8'h02] = v;
  endtask

  task rd(input logic [7:0] x, input logic [63:0] e, input logic f);
    op(1, 0, x, 64'h0, 0, 0);
    eq.push_back(f ? {1'b1, 64'h0} : {1'b0, e});
  endtask

  // Expected type: global off, low-memory, variable, then default
  task lk(input logic [35:0] a);
    op(0, 0, 8'h00, 64'h0, 1, a);
    if (!defq[11]) tq.push_back(8'h00);
    else if (defq[10] && a[35:20] == 16'h0)
      tq.push_back(!a[19] ? fx[0][a[18:16]*8 +: 8] : !a[18] ?
        fx[1 + a[17]][a[16:14]*8 +: 8] : fx[3 + a[17:15]][a[14:12]*8 +: 8]);
    else tq.push_back(var_hit ? var_type : defq[7:0]);
  endtask

  // Results are settled by the falling edge
  always @(negedge mclk)
  begin
    if (reg_rvalid_q || protection_fault_q) chk_reg(eq.pop_front(),
      {protection_fault_q, protection_fault_q ? 64'h0 : reg_rdata_q});
    if (mem_type_valid_q) chk_type(tq.pop_front(), mem_type_q);
  end

  initial
  begin
    #100000;
    fails++;
    print_verdict();
  end

  initial
  begin
    {reg_rd, reg_wr, reg_index, reg_wdata, lookup_req, lookup_addr} = 0;
    {var_hit, var_type, defq} = 0;
    fx = '{default: 64'h0};
    srst = 1;
    i = $urandom(61202);
    repeat (5) @(posedge mclk);
    #1 srst = 0;
    rd(8'h01, 64'h0, 0);
    lk(36'h0000C1000);
    rd(8'h00, 64'h508, 0);
    wr(8'h00, 64'h0, 1);
    rd(8'h0D, 64'h0, 1);
    for (i = 0; i < 9; i++)
      wr(8'h01, i == 8 ? 64'hFF : i, !(i inside {0, 1, 4, 5, 6}));
    rd(8'h01, defq, 0);
    for (i = 8; i < 64; i++)
      if (i != 10 && i != 11) wr(8'h01, 64'h806 | 64'h1 << i, 1);
    chk_reg(65'h1000, {33'h0, feature_flags_q});
    for (i = 2; i < 13; i++)
    begin
      for (k = 0; k < 8; k++) d[k*8 +: 8] = lg[$urandom % 5];
      wr(i, d, 0);
      rd(i, d, 0);
    end
    wr(8'h05, {d[63:16], 8'h02, d[7:0]}, 1);
    for (k = 0; k < 3; k++)
    begin
      wr(8'h01, (k + 1) << 10 | lg[$urandom % 5], 0);
      for (i = 0; i < 6; i++) lk(ba[i]);
      for (i = 0; i < 60; i++) lk($urandom % 2 ? {16'h0, 20'($urandom)} :
        {4'h0, 32'($urandom)});
    end
    op(0, 0, 8'h00, 64'h0, 0, 0);
    repeat (2) @(posedge mclk);
    #1 srst = 1;
    defq = 0;
    fx = '{default: 64'h0};
    repeat (2) @(posedge mclk);
    #1 srst = 0;
    rd(8'h02, 64'h0, 0);
    lk(36'h000000100);
    op(0, 0, 8'h00, 64'h0, 0, 0);
    repeat (3) @(posedge mclk);
    if (eq.size() + tq.size() != 0) fails++;
    print_verdict();
  end
endmodule
`default_nettype wire
